// ### bsc_pkg.sv
// constants, enumerations and carriers for the pad-cell scan chain block
// assumes a four-wire test port driven by an external board tester
package bsc_pkg;

  // ----------------------------------------------------------------------
  // chain geometry and default pad mix (io pads 3 cells, out 2, in 1)
  // ----------------------------------------------------------------------
  localparam int BSC_CHAIN_LEN = 449;
  localparam int BSC_N_IN_DEF = 8;
  localparam int BSC_N_OUT_DEF = 30;
  localparam int BSC_N_IO_DEF = 127;
  localparam int BSC_IR_W = 4;
  localparam int BSC_ID_W = 32;

  // ----------------------------------------------------------------------
  // instruction codes and capture patterns
  // ----------------------------------------------------------------------
  localparam logic [3:0] BSC_OP_EXTEST = 4'h0;
  localparam logic [3:0] BSC_OP_SAMPLE = 4'h1;
  localparam logic [3:0] BSC_OP_IDCODE = 4'h2;
  localparam logic [3:0] BSC_OP_BYPASS = 4'hf;
  localparam logic [3:0] BSC_IR_CAPTURE = 4'h1;
  // processor identity shown to the emulator; value is arbitrary
  localparam logic [31:0] BSC_EMU_ID = 32'h1234_5679;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    BSC_TLR, BSC_RTI, BSC_SEL_DR, BSC_CAP_DR, BSC_SH_DR, BSC_EX1_DR, BSC_PA_DR,
    BSC_EX2_DR, BSC_UPD_DR, BSC_SEL_IR, BSC_CAP_IR, BSC_SH_IR, BSC_EX1_IR,
    BSC_PA_IR, BSC_EX2_IR, BSC_UPD_IR
  } bsc_tap_state_t;

  typedef enum logic [1:0] {BSC_DR_CHAIN, BSC_DR_ID, BSC_DR_BYP} bsc_dr_sel_t;

  typedef struct packed {
    logic tms;
    logic tdi;
  } bsc_link_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bsc_link_out_t;

  // sixteen-state controller step on one rising test-clock edge
  function automatic bsc_tap_state_t bsc_tap_next(bsc_tap_state_t s, logic tms);
    unique case (s)
      BSC_TLR: return tms ? BSC_TLR : BSC_RTI;
      BSC_RTI: return tms ? BSC_SEL_DR : BSC_RTI;
      BSC_SEL_DR: return tms ? BSC_SEL_IR : BSC_CAP_DR;
      BSC_CAP_DR: return tms ? BSC_EX1_DR : BSC_SH_DR;
      BSC_SH_DR: return tms ? BSC_EX1_DR : BSC_SH_DR;
      BSC_EX1_DR: return tms ? BSC_UPD_DR : BSC_PA_DR;
      BSC_PA_DR: return tms ? BSC_EX2_DR : BSC_PA_DR;
      BSC_EX2_DR: return tms ? BSC_UPD_DR : BSC_SH_DR;
      BSC_UPD_DR: return tms ? BSC_SEL_DR : BSC_RTI;
      BSC_SEL_IR: return tms ? BSC_TLR : BSC_CAP_IR;
      BSC_CAP_IR: return tms ? BSC_EX1_IR : BSC_SH_IR;
      BSC_SH_IR: return tms ? BSC_EX1_IR : BSC_SH_IR;
      BSC_EX1_IR: return tms ? BSC_UPD_IR : BSC_PA_IR;
      BSC_PA_IR: return tms ? BSC_EX2_IR : BSC_PA_IR;
      BSC_EX2_IR: return tms ? BSC_UPD_IR : BSC_SH_IR;
      BSC_UPD_IR: return tms ? BSC_SEL_DR : BSC_RTI;
    endcase
  endfunction

  // which data register sits between tdi and tdo
  function automatic bsc_dr_sel_t bsc_dr_sel(logic [3:0] ir, logic scan);
    if (scan && (ir == BSC_OP_EXTEST || ir == BSC_OP_SAMPLE)) return BSC_DR_CHAIN;
    if (!scan && ir == BSC_OP_IDCODE) return BSC_DR_ID;
    return BSC_DR_BYP;
  endfunction

endpackage

// ### bsc_scan_top.sv
// pad-cell scan chain with its test port controller, pad muxing and mode select
// assumes tck_i from the tester, pads and core drivers on mclk_i
//
// Operation
// - test port reaches scan logic only if mode select was high at the last chip reset
// - scan mode decodes sample, external test and bypass instructions
// - emulator mode answers identification with a processor code, not standard one
// - chain holds 449 cells covering all pads and their controls
// - each input pad has one cell capturing the pad level
// - each output pad has a data cell and a high-impedance control cell
// - each two-way pad has data, captured input and direction cells
module bsc_scan_top #(
  parameter int N_IN = bsc_pkg::BSC_N_IN_DEF,
  parameter int N_OUT = bsc_pkg::BSC_N_OUT_DEF,
  parameter int N_IO = bsc_pkg::BSC_N_IO_DEF,
  parameter int CL = bsc_pkg::BSC_CHAIN_LEN
) (
  // system clock and chip reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // test port, clocked by the tester
  input wire logic tck_i,
  input wire logic test_logic_reset_low_i,
  input wire bsc_pkg::bsc_link_in_t link_i,
  output bsc_pkg::bsc_link_out_t link_o,
  // mode straps
  input wire logic scan_or_emulator_select_i,
  output logic scan_active_o,
  output logic emulator_active_o,
  // pads and core drivers
  input wire logic [N_IN+N_IO-1:0] pad_in_i,
  input wire logic [N_OUT+N_IO-1:0] core_out_i,
  input wire logic [N_OUT+N_IO-1:0] core_oe_i,
  output logic [N_OUT+N_IO-1:0] pad_out_o,
  output logic [N_OUT+N_IO-1:0] pad_oe_o
);
  import bsc_pkg::*;

  localparam int OUT_BASE = N_IN;
  localparam int IO_BASE = N_IN + 2 * N_OUT;
  localparam int NP = N_OUT + N_IO;

  // ----------------------------------------------------------------------
  // chain layout
  // ----------------------------------------------------------------------
  // bit 0 sits next to tdo; input-only, then output-only, then two-way pads
  function automatic int in_pos(int q);
    return (q < N_IN) ? q : IO_BASE + 3 * (q - N_IN);
  endfunction
  function automatic int dat_pos(int p);
    return (p < N_OUT) ? OUT_BASE + 2 * p : IO_BASE + 3 * (p - N_OUT) + 1;
  endfunction
  function automatic int ctl_pos(int p);
    return dat_pos(p) + 1;
  endfunction

  if (N_IN + 2 * N_OUT + 3 * N_IO != CL || CL != BSC_CHAIN_LEN) begin : g_chk
    $error("pad mix does not fill the scan chain");
  end

  // ----------------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------------
  typedef struct packed {
    bsc_tap_state_t state;
    logic [BSC_IR_W-1:0] ir;
    logic [BSC_IR_W-1:0] ir_sh;
    logic [CL-1:0] dr;
    logic [CL-1:0] upd;
    logic byp;
    logic [BSC_ID_W-1:0] id_sh;
    logic ms1;
    logic ms2;
    logic ms3;
    logic mst;
    logic mode;
    logic [CL-1:0] cs1;
    logic [CL-1:0] cs2;
    logic [CL-1:0] cs3;
    logic [CL-1:0] cst;
    logic ext;
    logic tgl;
  } bsc_tck_st_t;

  typedef struct packed {
    logic ss1;
    logic ss2;
    logic ss3;
    logic sst;
    logic mode;
    logic emu;
    logic es1;
    logic es2;
    logic es3;
    logic est;
    logic ts1;
    logic ts2;
    logic ts3;
    logic [CL-1:0] upd;
    logic [NP-1:0] pout;
    logic [NP-1:0] poe;
  } bsc_m_st_t;

  localparam bsc_tck_st_t T_RST = '{ir: BSC_OP_BYPASS, state: BSC_TLR, default: '0};

  bsc_tck_st_t t_reg, t_next;
  bsc_m_st_t m_reg, m_next;
  bsc_link_out_t lo_reg;
  logic [CL-1:0] cap_raw;
  bsc_dr_sel_t sel;

  // ----------------------------------------------------------------------
  // capture vector: pad levels and the drivers presented to the pads
  // ----------------------------------------------------------------------
  for (genvar gq = 0; gq < N_IN + N_IO; gq++) begin : g_in
    assign cap_raw[in_pos(gq)] = pad_in_i[gq];
  end
  for (genvar gp = 0; gp < NP; gp++) begin : g_out
    assign cap_raw[dat_pos(gp)] = m_reg.pout[gp];
    assign cap_raw[ctl_pos(gp)] = m_reg.poe[gp];
  end

  assign sel = bsc_dr_sel(t_reg.ir, t_reg.mode);

  // ----------------------------------------------------------------------
  // test clock domain
  // ----------------------------------------------------------------------
  // controller, instruction and data registers; pad captures pass three flops
  always_comb begin
    t_next = t_reg;
    t_next.ms1 = m_reg.mode;
    t_next.ms2 = t_reg.ms1;
    t_next.ms3 = t_reg.ms2;
    t_next.mst = (t_reg.ms2 == t_reg.ms3) ? t_reg.ms2 : t_reg.mst; // moves once flops agree
    t_next.cs1 = cap_raw;
    t_next.cs2 = t_reg.cs1;
    t_next.cs3 = t_reg.cs2;
    // a bit moves only once the second and third flops agree
    t_next.cst = (t_reg.cs2 & t_reg.cs3) | (t_reg.cst & (t_reg.cs2 ^ t_reg.cs3));
    t_next.state = bsc_tap_next(t_reg.state, link_i.tms);
    unique case (t_reg.state)
      BSC_TLR: begin
        t_next.mode = t_reg.mst; // mode only re-read in reset, never mid-session
        t_next.ir = t_reg.mst ? BSC_OP_BYPASS : BSC_OP_IDCODE;
        t_next.ext = 1'b0;
      end
      BSC_CAP_DR: begin
        unique case (sel)
          BSC_DR_CHAIN: t_next.dr = t_reg.cst;
          BSC_DR_ID: t_next.id_sh = BSC_EMU_ID;
          BSC_DR_BYP: t_next.byp = 1'b0;
        endcase
      end
      BSC_SH_DR: begin
        unique case (sel)
          BSC_DR_CHAIN: t_next.dr = {link_i.tdi, t_reg.dr[CL-1:1]};
          BSC_DR_ID: t_next.id_sh = {link_i.tdi, t_reg.id_sh[BSC_ID_W-1:1]};
          BSC_DR_BYP: t_next.byp = link_i.tdi;
        endcase
      end
      BSC_UPD_DR: begin
        // sample also preloads the update cells ahead of external test
        if (sel == BSC_DR_CHAIN) begin
          t_next.upd = t_reg.dr;
          t_next.tgl = ~t_reg.tgl;
        end
      end
      BSC_CAP_IR: t_next.ir_sh = BSC_IR_CAPTURE;
      BSC_SH_IR: t_next.ir_sh = {link_i.tdi, t_reg.ir_sh[BSC_IR_W-1:1]};
      BSC_UPD_IR: begin
        t_next.ir = t_reg.ir_sh;
        t_next.ext = t_reg.mode && (t_reg.ir_sh == BSC_OP_EXTEST);
      end
      default: ;
    endcase
  end

  // async test reset returns the controller to its reset state
  always_ff @(posedge tck_i or negedge test_logic_reset_low_i) begin
    if (!test_logic_reset_low_i) begin
      t_reg <= T_RST;
    end else begin
      t_reg <= t_next;
    end
  end

  // tdo changes on the falling edge so the tester samples a settled bit
  always_ff @(negedge tck_i or negedge test_logic_reset_low_i) begin
    if (!test_logic_reset_low_i) begin
      lo_reg <= '0;
    end else begin
      lo_reg.tdo_oe <= (t_reg.state == BSC_SH_DR) || (t_reg.state == BSC_SH_IR);
      if (t_reg.state == BSC_SH_IR) begin
        lo_reg.tdo <= t_reg.ir_sh[0];
      end else if (sel == BSC_DR_CHAIN) begin
        lo_reg.tdo <= t_reg.dr[0];
      end else if (sel == BSC_DR_ID) begin
        lo_reg.tdo <= t_reg.id_sh[0];
      end else begin
        lo_reg.tdo <= t_reg.byp;
      end
    end
  end

  // ----------------------------------------------------------------------
  // system clock domain
  // ----------------------------------------------------------------------
  // mode strap, external-test level, update handshake and pad drivers
  always_comb begin
    m_next = m_reg;
    m_next.ss1 = scan_or_emulator_select_i;
    m_next.ss2 = m_reg.ss1;
    m_next.ss3 = m_reg.ss2;
    m_next.sst = (m_reg.ss2 == m_reg.ss3) ? m_reg.ss2 : m_reg.sst;
    m_next.es1 = t_reg.ext;
    m_next.es2 = m_reg.es1;
    m_next.es3 = m_reg.es2;
    m_next.est = (m_reg.es2 == m_reg.es3) ? m_reg.es2 : m_reg.est;
    m_next.ts1 = t_reg.tgl;
    m_next.ts2 = m_reg.ts1;
    m_next.ts3 = m_reg.ts2;
    // the update cells hold still for many tck cycles after each toggle
    if (m_reg.ts2 != m_reg.ts3) begin
      m_next.upd = t_reg.upd;
    end
    for (int p = 0; p < NP; p++) begin
      if (m_reg.est && m_reg.mode) begin
        m_next.pout[p] = m_reg.upd[dat_pos(p)];
        m_next.poe[p] = m_reg.upd[ctl_pos(p)];
      end else begin
        m_next.pout[p] = core_out_i[p];
        m_next.poe[p] = core_oe_i[p];
      end
    end
    if (rst_i) begin
      m_next = '0;
      m_next.ss1 = scan_or_emulator_select_i;
      m_next.ss2 = m_reg.ss1;
      m_next.ss3 = m_reg.ss2;
      m_next.sst = (m_reg.ss2 == m_reg.ss3) ? m_reg.ss2 : m_reg.sst;
      m_next.mode = m_reg.sst; // strap is caught during chip reset only
      m_next.emu = ~m_reg.sst;
    end
  end

  always_ff @(posedge mclk_i) begin
    m_reg <= m_next;
  end

  assign link_o = lo_reg;
  assign scan_active_o = m_reg.mode;
  assign emulator_active_o = m_reg.emu;
  assign pad_out_o = m_reg.pout;
  assign pad_oe_o = m_reg.poe;

  // ----------------------------------------------------------------------
  // assertions and cover points
  // ----------------------------------------------------------------------
  AST_TLR_FIVE: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    link_i.tms [*5] |=> t_reg.state == BSC_TLR) else $error("five tms highs missed reset");
  AST_IR_CAPTURE: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.state == BSC_CAP_IR |=> t_reg.ir_sh == BSC_IR_CAPTURE) else $error("bad ir capture");
  AST_BYPASS_ONE: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.state == BSC_SH_DR && sel == BSC_DR_BYP |=> t_reg.byp == $past(link_i.tdi))
    else $error("bypass is not one bit");
  AST_EMU_ID: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.state == BSC_CAP_DR && !t_reg.mode && t_reg.ir == BSC_OP_IDCODE
    |=> t_reg.id_sh == BSC_EMU_ID) else $error("emulator id not loaded");
  AST_NO_CHAIN_EMU: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    !t_reg.mode |-> sel != BSC_DR_CHAIN && !t_reg.ext) else $error("chain reached in emulator mode");
  AST_CHAIN_SHIFT: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.state == BSC_SH_DR && sel == BSC_DR_CHAIN
    |=> t_reg.dr[0] == $past(t_reg.dr[1]) && t_reg.dr[CL-1] == $past(link_i.tdi))
    else $error("chain shift wrong");
  AST_CHAIN_CAPTURE: assert property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.state == BSC_CAP_DR && sel == BSC_DR_CHAIN |=> t_reg.dr == $past(t_reg.cst))
    else $error("chain capture wrong");
  AST_EXTEST_DRIVE: assert property (@(posedge mclk_i) disable iff (rst_i)
    m_reg.est && m_reg.mode |=> pad_out_o[0] == $past(m_reg.upd[dat_pos(0)])
    && pad_oe_o[NP-1] == $past(m_reg.upd[ctl_pos(NP-1)])) else $error("extest pad not driven");
  AST_CORE_DRIVE: assert property (@(posedge mclk_i) disable iff (rst_i)
    !m_reg.mode |=> pad_out_o == $past(core_out_i)) else $error("core lost pads");
  AST_MODE_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    !$past(rst_i) |-> $stable(m_reg.mode) && m_reg.emu == !m_reg.mode)
    else $error("mode changed outside reset");

  COV_EXTEST: cover property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.ext && t_reg.state == BSC_UPD_DR);
  COV_EMU_ID: cover property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    sel == BSC_DR_ID && t_reg.state == BSC_SH_DR);
  COV_BYPASS: cover property (@(posedge tck_i) disable iff (!test_logic_reset_low_i)
    t_reg.mode && sel == BSC_DR_BYP && t_reg.state == BSC_SH_DR);
  COV_PAD_EXTEST: cover property (@(posedge mclk_i) disable iff (rst_i)
    m_reg.est && m_reg.mode && m_reg.ts2 != m_reg.ts3);

endmodule

// ### bsc_tester_model.sv
// tester model: drives the four-wire test port, tck runs only inside frames
// assumes the device samples tms/tdi on rising tck and moves tdo on falling tck
module bsc_tester_model
  import bsc_pkg::*;
(
  // test port toward the device
  output logic tck_o,
  output logic test_logic_reset_low_o,
  output bsc_pkg::bsc_link_in_t link_o,
  input wire bsc_pkg::bsc_link_out_t link_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  // tck parks low between frames; factory test selects stay low on the board
  initial begin
    tck_o = 1'h0;
    test_logic_reset_low_o = 1'h0;
    link_o = 2'h0;
  end

  // ------------------------------------------------------------
  // frame tasks
  // ------------------------------------------------------------
  // one 64 ns period; tdo is taken just before the rise that shifts it
  task automatic step(input logic m, input logic d, output logic q);
    link_o.tms = m;
    link_o.tdi = d;
    #16;
    q = link_i.tdo;
    tck_o = 1'h1;
    #32;
    tck_o = 1'h0;
    #16;
  endtask

  // async pulse, then five tms highs reach the reset state, then idle
  task automatic reset_tap();
    logic q;
    test_logic_reset_low_o = 1'h0;
    step(1'h1, 1'h0, q);
    test_logic_reset_low_o = 1'h1;
    for (int i = 0; i < 5; i++)
      step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask

  // from idle: load a 4-bit code lsb first, return the captured pattern
  task automatic shift_ir(input logic [3:0] code, output logic [3:0] cap);
    logic q;
    step(1'h1, 1'h0, q);
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < 4; i++)
      step(i == 3, code[i], cap[i]);
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask

  // from idle: shift n bits through the selected data register
  task automatic shift_dr(input logic [459:0] din, input int n, output logic [459:0] dout);
    logic q;
    dout = 460'h0;
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
    step(1'h0, 1'h0, q);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
endmodule

// ### tb_boundary_scan_chain.sv
// self-checking bench for the pad-cell scan chain
// assumes the tester model owns tck; pads and core drivers move on mclk
module tb_boundary_scan_chain;
  timeunit 1ns;
  timeprecision 100ps;
  import bsc_pkg::*;
  localparam int NPI = BSC_N_IN_DEF + BSC_N_IO_DEF;
  localparam int NPO = BSC_N_OUT_DEF + BSC_N_IO_DEF;
  localparam int IOB = BSC_N_IN_DEF + 2 * BSC_N_OUT_DEF;
  localparam logic [448:0] PRELOAD = 449'({29{16'h3c96}});

  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic scan_sel = 1'h0;
  logic [NPI-1:0] pad_in = '0;
  logic [NPO-1:0] core_out = '0;
  logic [NPO-1:0] core_oe = '0;
  logic tck, test_logic_reset_low, scan_act, emu_act;
  bsc_link_in_t link_in;
  bsc_link_out_t link_out;
  logic [NPO-1:0] pad_out, pad_oe;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 mclk = ~mclk;

  bsc_scan_top bsc_scan_top_inst (
    .mclk_i(mclk), .rst_i(rst), .tck_i(tck),
    .test_logic_reset_low_i(test_logic_reset_low), .link_i(link_in), .link_o(link_out),
    .scan_or_emulator_select_i(scan_sel), .scan_active_o(scan_act),
    .emulator_active_o(emu_act), .pad_in_i(pad_in), .core_out_i(core_out),
    .core_oe_i(core_oe), .pad_out_o(pad_out), .pad_oe_o(pad_oe)
  );

  bsc_tester_model bsc_tester_model_inst (
    .tck_o(tck), .test_logic_reset_low_o(test_logic_reset_low),
    .link_o(link_in), .link_i(link_out)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [511:0] got, input logic [511:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a hung handshake would stall forever, so a cycle ceiling cuts the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      report_and_stop();
    end
  end

  // strap is only caught while chip reset is held; test logic reset follows
  task automatic chip_reset(input logic sel);
    @(posedge mclk);
    #2;
    scan_sel = sel;
    rst = 1'h1;
    repeat (10) @(posedge mclk);
    #2;
    rst = 1'h0;
    repeat (2) @(posedge mclk);
    #2;
    check(scan_act, sel);
    check(emu_act, !sel);
    bsc_tester_model_inst.reset_tap();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_emu_mode();
    logic [459:0] dout;
    logic [3:0] cap;
    // non-zero core drive so a wrongly enabled external test would show on the pads
    @(posedge mclk);
    #2;
    core_out = NPO'({10{16'h69c3}});
    core_oe = NPO'({10{16'ha55a}});
    bsc_tester_model_inst.shift_dr(460'h0, 32, dout);
    check(dout[31:0], BSC_EMU_ID);
    bsc_tester_model_inst.shift_ir(BSC_OP_SAMPLE, cap);
    check(cap, BSC_IR_CAPTURE);
    bsc_tester_model_inst.shift_dr({456'h0, 4'hb}, 4, dout);
    check(dout[3:0], 4'h6);
    bsc_tester_model_inst.shift_ir(BSC_OP_EXTEST, cap);
    repeat (10) @(posedge mclk);
    #2;
    check(pad_out, core_out);
    check(pad_oe, core_oe);
  endtask

  // bypass: one stage, captured zero first; identification refused in scan mode
  task automatic test_bypass();
    logic [459:0] dout;
    logic [3:0] cap;
    bsc_tester_model_inst.shift_dr({428'h0, 32'h8765_4321}, 32, dout);
    check(dout[31:0], 32'h0eca_8642);
    bsc_tester_model_inst.shift_ir(BSC_OP_BYPASS, cap);
    bsc_tester_model_inst.shift_dr({428'h0, 32'h8765_4321}, 32, dout);
    check(dout[31:0], 32'h0eca_8642);
    bsc_tester_model_inst.shift_ir(BSC_OP_IDCODE, cap);
    bsc_tester_model_inst.shift_dr({428'h0, 32'h8765_4321}, 32, dout);
    check(dout[31:0], 32'h0eca_8642);
    check(link_out.tdo_oe, 1'h0);
  endtask

  // capture layout, then 8 marker bits prove the chain is exactly 449 long
  task automatic test_sample_chain();
    logic [459:0] dout;
    logic [448:0] e;
    logic [3:0] cap;
    @(posedge mclk);
    #2;
    pad_in = NPI'({9{16'h5a3c}});
    core_out = NPO'({10{16'hc3a5}});
    core_oe = NPO'({10{16'h96e1}});
    repeat (6) @(posedge mclk);
    #2;
    check(pad_out, core_out);
    for (int q = 0; q < BSC_N_IN_DEF; q++)
      e[q] = pad_in[q];
    for (int p = 0; p < BSC_N_OUT_DEF; p++) begin
      e[BSC_N_IN_DEF + 2 * p] = core_out[p];
      e[BSC_N_IN_DEF + 2 * p + 1] = core_oe[p];
    end
    for (int k = 0; k < BSC_N_IO_DEF; k++) begin
      e[IOB + 3 * k] = pad_in[BSC_N_IN_DEF + k];
      e[IOB + 3 * k + 1] = core_out[BSC_N_OUT_DEF + k];
      e[IOB + 3 * k + 2] = core_oe[BSC_N_OUT_DEF + k];
    end
    bsc_tester_model_inst.shift_ir(BSC_OP_SAMPLE, cap);
    bsc_tester_model_inst.shift_dr({3'h0, PRELOAD, 8'hb4}, 457, dout);
    check(dout[448:0], e);
    check(dout[456:449], 8'hb4);
    // an update under sample must leave the pads with the core
    repeat (10) @(posedge mclk);
    #2;
    check(pad_out, core_out);
    check(pad_oe, core_oe);
  endtask

  // preloaded cells drive the pads under external test; reset hands pads back
  task automatic test_extest();
    logic [NPO-1:0] eo, ee;
    logic [3:0] cap;
    for (int p = 0; p < BSC_N_OUT_DEF; p++) begin
      eo[p] = PRELOAD[BSC_N_IN_DEF + 2 * p];
      ee[p] = PRELOAD[BSC_N_IN_DEF + 2 * p + 1];
    end
    for (int k = 0; k < BSC_N_IO_DEF; k++) begin
      eo[BSC_N_OUT_DEF + k] = PRELOAD[IOB + 3 * k + 1];
      ee[BSC_N_OUT_DEF + k] = PRELOAD[IOB + 3 * k + 2];
    end
    bsc_tester_model_inst.shift_ir(BSC_OP_EXTEST, cap);
    repeat (10) @(posedge mclk);
    #2;
    check(pad_out, eo);
    check(pad_oe, ee);
    bsc_tester_model_inst.reset_tap();
    repeat (10) @(posedge mclk);
    #2;
    check(pad_out, core_out);
    check(pad_oe, core_oe);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    chip_reset(1'h0);
    test_emu_mode();
    chip_reset(1'h1);
    test_bypass();
    test_sample_chain();
    test_extest();
    report_and_stop();
  end
endmodule
